//--- common/pio_pkg.sv
// constants, types and helpers for the parallel i/o port block
//
// Contract
// [RQ1] six ports, up to 46 lines; this block carries ports a to d only.
// [RQ2] port a: three inputs, three outputs, two bidirectional, all timer shared.
// [RQ3] single-chip: every port b pin is an output from port b data.
// [RQ4] expanded or test: port b pins carry high address bits 8 to 15.
// [RQ5] single-chip or bootstrap reset drives all port b pins low.
// [RQ6] port c is bidirectional gpio in single-chip, low address/data bus expanded.
// [RQ7] reset clears the port c output data register.
// [RQ8] reset clears port c direction so all port c pins are inputs; in expanded and test modes the code drives c_oe from ext_ad_oe instead.
// [RQ9] expanded/test: port c data accesses go to the external bus.
// [RQ10] each active strobe a edge captures port c pins into the latch register.
// [RQ11] writing the latch register updates port c data and clears the strobe flag; the code clears the flag only after a control read has seen it set.
// [RQ12] edge select 0 picks falling edge, 1 picks rising edge.
// [RQ13] port c direction bit 0 means input, 1 means output.
// [RQ14] port d bits 0 to 5 are gpio or serial/spi signals in every mode.
// [RQ15] reset clears port d direction, all port d pins inputs.
// [RQ16] port d direction bit 0 means input, 1 means output.
// [RQ17] d5 output with spi master: gpio output and mode-fault detection disabled.
// [RQ18] port d data and direction bits 7 and 6 read zero.
// [RQ19] control register bit 7 sets direction of port a bit 7.
// [RQ20] control register bit 3: port a bit 3 input at 0, output at 1.
// [RQ21] output compare control of pin a3 overrides its direction bit.
package pio_pkg;

	// =====================================================================
	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_PORT_A     = 14'h1000;
	localparam logic [13:0] IDX_STROBE_CTL = 14'h1002;
	localparam logic [13:0] IDX_PORT_C     = 14'h1003;
	localparam logic [13:0] IDX_PORT_B     = 14'h1004;
	localparam logic [13:0] IDX_PORT_C_LAT = 14'h1005;
	localparam logic [13:0] IDX_PORT_C_DIR = 14'h1007;
	localparam logic [13:0] IDX_PORT_D     = 14'h1008;
	localparam logic [13:0] IDX_PORT_D_DIR = 14'h1009;
	localparam logic [13:0] IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR      = 14'h1026;

	// =====================================================================
	// reset values and field positions
	localparam logic [7:0] RST_BYTE        = 8'h00;
	localparam logic [5:0] RST_PORT_D      = 6'h00;
	localparam logic       RST_EDGE_SEL    = 1'b1;
	localparam int         BIT_FLAG        = 7;
	localparam int         BIT_EDGE_SEL    = 1;
	localparam int         BIT_A7_DIR      = 7;
	localparam int         BIT_A3_DIR      = 3;
	localparam int         SYNC_W          = 20;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// =====================================================================
	// operating modes, decoded from the strap pins
	typedef enum logic [1:0] {MODE_BOOT, MODE_SINGLE, MODE_TEST, MODE_EXPANDED} mode_t;

	function automatic mode_t mode_decode(input logic [1:0] strap);
		case (strap)
			2'h0: mode_decode = MODE_BOOT;
			2'h1: mode_decode = MODE_SINGLE;
			2'h2: mode_decode = MODE_TEST;
			default: mode_decode = MODE_EXPANDED;
		endcase
	endfunction : mode_decode

	function automatic logic reg_hit(input logic [15:0] addr, input logic [13:0] idx);
		reg_hit = (addr == {idx, 2'h0});
	endfunction : reg_hit

endpackage : pio_pkg

//--- design/pio_ports.sv
// parallel i/o ports a to d with axi4-lite register access
`timescale 1ns/10ps
module pio_ports
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// mode strap, caught while reset is high
	input  wire logic [1:0]  mode_strap,
	// axi4-lite slave
	input  wire logic [15:0] awaddr,
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output      logic        wready,
	output      logic [1:0]  bresp,
	output      logic        bvalid,
	input  wire logic        bready,
	input  wire logic [15:0] araddr,
	input  wire logic        arvalid,
	output      logic        arready,
	output      logic [31:0] rdata,
	output      logic [1:0]  rresp,
	output      logic        rvalid,
	input  wire logic        rready,
	// port a pins and timer
	input  wire logic [7:0]  a_in,
	output      logic [7:0]  a_out,
	output      logic [7:0]  a_oe,
	input  wire logic [2:0]  timer_oc_en,
	input  wire logic [2:0]  timer_oc_val,
	input  wire logic        oc_pa3_ctrl,
	input  wire logic        oc_pa3_val,
	// port b pins and high address
	output      logic [7:0]  b_out,
	input  wire logic [7:0]  addr_high,
	// port c pins, strobe and external bus
	input  wire logic [7:0]  c_in,
	output      logic [7:0]  c_out,
	output      logic [7:0]  c_oe,
	input  wire logic        strobe_a_input,
	input  wire logic [7:0]  ext_ad_out,
	input  wire logic [7:0]  ext_ad_oe,
	output      logic        ext_port_c_req,
	output      logic        ext_port_c_we,
	output      logic [7:0]  ext_port_c_wdata,
	input  wire logic [7:0]  ext_port_c_rdata,
	// port d pins and serial subsystems
	input  wire logic [5:0]  d_in,
	output      logic [5:0]  d_out,
	output      logic [5:0]  d_oe,
	input  wire logic [5:0]  alt_d_en,
	input  wire logic [5:0]  alt_d_out,
	input  wire logic [5:0]  alt_d_oe,
	input  wire logic        spi_master_select,
	output      logic        mode_fault_disable
);

	// =====================================================================
	// state
	mode_t             mode;
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [SYNC_W-1:0] sync3;
	logic [SYNC_W-1:0] clean;
	logic              strobe_prev;
	logic [7:0]        port_a_data;
	logic [7:0]        port_b_data;
	logic [7:0]        port_c_data;
	logic [7:0]        port_c_strobe_latch;
	logic [7:0]        port_c_direction;
	logic [5:0]        port_d_data;
	logic [5:0]        port_d_direction;
	logic [7:0]        pulse_accum_ctrl_and_port_a_data_dir;
	logic              strobe_a_edge_select;
	logic              strobe_flag;
	logic              flag_armed;
	logic              aw_held;
	logic [15:0]       aw_addr_q;
	logic              w_held;
	logic [7:0]        w_byte_q;
	logic              w_lane0_q;

	// =====================================================================
	// pin synchronisers: a change counts once stages two and three agree
	wire [SYNC_W-1:0] pin_raw   = {strobe_a_input, d_in, c_in, a_in[7], a_in[3], a_in[2:0]};
	wire [SYNC_W-1:0] sync_diff = sync2 ^ sync3;
	wire [SYNC_W-1:0] next_clean = (~sync_diff & sync3) | (sync_diff & clean);
	// reset loads the settled pin level, so a pin idling high gives no false edge afterwards
	always_ff @(posedge clock) begin
		sync1 <= pin_raw;
		sync2 <= sync1;
		sync3 <= sync2;
		if (sys_rst) begin
			clean <= sync3;
		end else begin
			clean <= next_clean;
		end
	end
	wire [2:0] a_pin_lo  = clean[2:0];
	wire       a_pin3    = clean[3];
	wire       a_pin7    = clean[4];
	wire [7:0] c_pin     = clean[12:5];
	wire [5:0] d_pin     = clean[18:13];
	wire       strobe_in = clean[19];
	// mode strap is loaded into the register while reset is asserted and held once it drops
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode <= mode_decode(mode_strap);
		end
	end
	wire is_single = (mode == MODE_SINGLE) || (mode == MODE_BOOT);

	// =====================================================================
	// axi4-lite slave; address and data may arrive in either order
	wire do_write = aw_held && w_held && !bvalid;
	wire do_read  = arvalid && arready;
	wire wr_lane  = do_write && w_lane0_q;

	wire ws_a   = reg_hit(aw_addr_q, IDX_PORT_A);
	wire ws_ctl = reg_hit(aw_addr_q, IDX_STROBE_CTL);
	wire ws_c   = reg_hit(aw_addr_q, IDX_PORT_C);
	wire ws_b   = reg_hit(aw_addr_q, IDX_PORT_B);
	wire ws_cl  = reg_hit(aw_addr_q, IDX_PORT_C_LAT);
	wire ws_cd  = reg_hit(aw_addr_q, IDX_PORT_C_DIR);
	wire ws_d   = reg_hit(aw_addr_q, IDX_PORT_D);
	wire ws_dd  = reg_hit(aw_addr_q, IDX_PORT_D_DIR);
	wire ws_pa  = reg_hit(aw_addr_q, IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR);
	wire ws_any = ws_a | ws_ctl | ws_c | ws_b | ws_cl | ws_cd | ws_d | ws_dd | ws_pa;
	wire rs_a   = reg_hit(araddr, IDX_PORT_A);
	wire rs_ctl = reg_hit(araddr, IDX_STROBE_CTL);
	wire rs_c   = reg_hit(araddr, IDX_PORT_C);
	wire rs_b   = reg_hit(araddr, IDX_PORT_B);
	wire rs_cl  = reg_hit(araddr, IDX_PORT_C_LAT);
	wire rs_cd  = reg_hit(araddr, IDX_PORT_C_DIR);
	wire rs_d   = reg_hit(araddr, IDX_PORT_D);
	wire rs_dd  = reg_hit(araddr, IDX_PORT_D_DIR);
	wire rs_pa  = reg_hit(araddr, IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR);
	wire rs_any = rs_a | rs_ctl | rs_c | rs_b | rs_cl | rs_cd | rs_d | rs_dd | rs_pa;
	assign awready = !aw_held;
	assign wready  = !w_held;
	assign arready = !rvalid;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_held   <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_held    <= 1'b0;
			w_byte_q  <= RST_BYTE;
			w_lane0_q <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held    <= 1'b1;
				w_byte_q  <= wdata[7:0];
				w_lane0_q <= wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= ws_any ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// =====================================================================
	// read data; pins read back where the bit is an input
	wire [7:0] a_read  = {pulse_accum_ctrl_and_port_a_data_dir[BIT_A7_DIR] ? port_a_data[7] : a_pin7,
		port_a_data[6:4], a_oe[3] ? a_out[3] : a_pin3, a_pin_lo};
	wire [7:0] c_read  = (port_c_direction & port_c_data) | (~port_c_direction & c_pin);
	wire [5:0] d_read  = (port_d_direction & port_d_data) | (~port_d_direction & d_pin);
	wire [7:0] ctl_rd  = {strobe_flag, 5'h00, strobe_a_edge_select, 1'b0};
	// [RQ9] external port c reads
	wire [7:0] c_value = is_single ? c_read : ext_port_c_rdata;
	// [RQ18] upper port d bits zero
	wire [7:0] rd_value = rs_a ? a_read : rs_ctl ? ctl_rd : rs_c ? c_value : rs_b ? port_b_data :
		rs_cl ? port_c_strobe_latch : rs_cd ? port_c_direction : rs_d ? {2'h0, d_read} :
		rs_dd ? {2'h0, port_d_direction} : rs_pa ? pulse_accum_ctrl_and_port_a_data_dir : 8'h00;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= RESP_OKAY;
		end else if (do_read) begin
			rvalid <= 1'b1;
			rdata  <= {24'h000000, rd_value};
			rresp  <= rs_any ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// =====================================================================
	// port registers
	wire wr_c_local = wr_lane && ws_c && is_single;
	wire wr_cl      = wr_lane && ws_cl;

	// [RQ5] [RQ7] [RQ8] [RQ15] reset values
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port_a_data                    <= RST_BYTE;
			port_b_data                    <= RST_BYTE;
			port_c_data                    <= RST_BYTE;
			port_c_direction               <= RST_BYTE;
			port_d_data                    <= RST_PORT_D;
			port_d_direction               <= RST_PORT_D;
			pulse_accum_ctrl_and_port_a_data_dir <= RST_BYTE;
			strobe_a_edge_select           <= RST_EDGE_SEL;
		end else begin
			if (wr_lane && ws_a) begin
				port_a_data <= w_byte_q;
			end
			if (wr_lane && ws_b) begin
				port_b_data <= w_byte_q;
			end
			// [RQ11] latch write drives port c
			if (wr_c_local || wr_cl) begin
				port_c_data <= w_byte_q;
			end
			if (wr_lane && ws_cd) begin
				port_c_direction <= w_byte_q;
			end
			if (wr_lane && ws_d) begin
				port_d_data <= w_byte_q[5:0];
			end
			if (wr_lane && ws_dd) begin
				port_d_direction <= w_byte_q[5:0];
			end
			if (wr_lane && ws_pa) begin
				pulse_accum_ctrl_and_port_a_data_dir <= w_byte_q;
			end
			if (wr_lane && ws_ctl) begin
				strobe_a_edge_select <= w_byte_q[BIT_EDGE_SEL];
			end
		end
	end

	// =====================================================================
	// strobe a capture and flag
	// [RQ12] edge polarity select
	wire strobe_edge = strobe_a_edge_select ? (strobe_in && !strobe_prev) : (!strobe_in && strobe_prev);
	wire flag_clear  = flag_armed && ((do_read && rs_cl) || wr_cl);
	wire next_flag   = strobe_edge || (strobe_flag && !flag_clear);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			strobe_prev         <= sync3[SYNC_W-1];
			strobe_flag         <= 1'b0;
			flag_armed          <= 1'b0;
			port_c_strobe_latch <= RST_BYTE;
		end else begin
			strobe_prev <= strobe_in;
			// [RQ10] capture port c pins
			if (strobe_edge) begin
				port_c_strobe_latch <= c_pin;
			end
			// [RQ11] set wins over clear
			strobe_flag <= next_flag;
			if (do_read && rs_ctl && strobe_flag) begin
				flag_armed <= 1'b1;
			end else if (flag_clear) begin
				flag_armed <= 1'b0;
			end
		end
	end

	// =====================================================================
	// external bus hand-off for port c in expanded and test modes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ext_port_c_req   <= 1'b0;
			ext_port_c_we    <= 1'b0;
			ext_port_c_wdata <= RST_BYTE;
		end else begin
			// [RQ9] pass access outward
			ext_port_c_req   <= !is_single && ((do_write && ws_c) || (do_read && rs_c));
			ext_port_c_we    <= do_write && ws_c;
			ext_port_c_wdata <= w_byte_q;
		end
	end

	// =====================================================================
	// pin drivers
	// [RQ1] [RQ2] port a shape: 2:0 in, 6:4 out, 7 and 3 two-way
	wire a3_dir = oc_pa3_ctrl | pulse_accum_ctrl_and_port_a_data_dir[BIT_A3_DIR];
	// [RQ19] [RQ20] [RQ21] port a directions
	assign a_oe  = {pulse_accum_ctrl_and_port_a_data_dir[BIT_A7_DIR], 3'h7, a3_dir, 3'h0};
	assign a_out = {port_a_data[7], (timer_oc_en & timer_oc_val) | (~timer_oc_en & port_a_data[6:4]),
		oc_pa3_ctrl ? oc_pa3_val : port_a_data[3], 3'h0};
	// [RQ3] [RQ4] port b source by mode
	assign b_out = is_single ? port_b_data : addr_high;
	// [RQ6] [RQ13] port c gpio or bus
	assign c_out = is_single ? port_c_data : ext_ad_out;
	assign c_oe  = is_single ? port_c_direction : ext_ad_oe;
	// [RQ17] d5 gpio output under spi master
	assign mode_fault_disable = port_d_direction[5] && spi_master_select;
	wire [5:0] alt_sel = alt_d_en & ~{mode_fault_disable, 5'h00};
	// [RQ14] [RQ16] port d gpio or subsystem
	assign d_out = (alt_sel & alt_d_out) | (~alt_sel & port_d_data);
	assign d_oe  = (alt_sel & alt_d_oe) | (~alt_sel & port_d_direction);

	// =====================================================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_latch_capture;
		strobe_edge |=> port_c_strobe_latch == $past(c_pin) && strobe_flag;
	endproperty
	a_latch_capture: assert property (p_latch_capture) else $error("strobe edge did not capture port c"); // [RQ10]
	property p_edge_polarity;
		(!strobe_a_edge_select && $fell(strobe_in)) |=> strobe_flag;
	endproperty
	a_edge_polarity: assert property (p_edge_polarity) else $error("falling edge missed with select 0"); // [RQ12]
	property p_b_single;
		is_single |-> b_out == port_b_data;
	endproperty
	a_b_single: assert property (p_b_single) else $error("port b not from data register"); // [RQ3]
	property p_b_expanded;
		!is_single |-> b_out == addr_high;
	endproperty
	a_b_expanded: assert property (p_b_expanded) else $error("port b not carrying high address"); // [RQ4]
	property p_reset_clear;
		$fell(sys_rst) |-> port_c_direction == 8'h00 && port_c_data == 8'h00 && port_d_direction == 6'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("direction or data not cleared by reset"); // [RQ8]
	property p_latch_write;
		wr_cl |=> port_c_data == $past(w_byte_q);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write did not reach port c data"); // [RQ11]
	property p_d5_master;
		(port_d_direction[5] && spi_master_select) |-> d_oe[5] && d_out[5] == port_d_data[5] && mode_fault_disable;
	endproperty
	a_d5_master: assert property (p_d5_master) else $error("d5 not gpio output under spi master"); // [RQ17]
	property p_d_upper_zero;
		(do_read && (rs_d || rs_dd)) |=> rdata[7:6] == 2'h0;
	endproperty
	a_d_upper_zero: assert property (p_d_upper_zero) else $error("port d upper bits not zero"); // [RQ18]
	property p_a3_override;
		oc_pa3_ctrl |-> a_oe[3] && a_out[3] == oc_pa3_val;
	endproperty
	a_a3_override: assert property (p_a3_override) else $error("output compare did not override a3"); // [RQ21]
	property p_ext_pass;
		(!is_single && do_write && ws_c) |=> ext_port_c_req && ext_port_c_we;
	endproperty
	a_ext_pass: assert property (p_ext_pass) else $error("port c access not passed outward"); // [RQ9]

	c_capture: cover property (strobe_edge ##[1:20] (do_read && rs_cl));
	c_flag_clear: cover property (strobe_flag ##1 flag_clear ##1 !strobe_flag);
	c_ext: cover property (ext_port_c_req && !ext_port_c_we);

endmodule : pio_ports

//--- dv/pin_world.sv
// far-side model: pin levels seen by the ports and the external memory bus
`timescale 1ns/10ps
module pin_world #(
	parameter logic [7:0] EXT_RD = 8'hC3
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       sys_rst,
	// design pin drives
	input  wire logic [7:0] a_out,
	input  wire logic [7:0] a_oe,
	input  wire logic [7:0] c_out,
	input  wire logic [7:0] c_oe,
	input  wire logic [5:0] d_out,
	input  wire logic [5:0] d_oe,
	// levels the outside world puts on undriven pins
	input  wire logic [7:0] ext_a,
	input  wire logic [7:0] ext_c,
	input  wire logic [5:0] ext_d,
	// resolved pin levels
	output      logic [7:0] a_in,
	output      logic [7:0] c_in,
	output      logic [5:0] d_in,
	// external memory bus
	input  wire logic       ext_port_c_req,
	input  wire logic       ext_port_c_we,
	input  wire logic [7:0] ext_port_c_wdata,
	output      logic [7:0] ext_port_c_rdata,
	output      logic [7:0] wr_count,
	output      logic       wr_we,
	output      logic [7:0] wr_data
);
	// =====================================================================
	// pin resolution: a driving port wins over the outside level
	assign a_in = (a_oe & a_out) | (~a_oe & ext_a);
	assign c_in = (c_oe & c_out) | (~c_oe & ext_c);
	assign d_in = (d_oe & d_out) | (~d_oe & ext_d);

	// =====================================================================
	// memory answers at once; request is a one-cycle pulse so log it here
	assign ext_port_c_rdata = EXT_RD;
	always @(posedge clock) begin
		if (sys_rst) begin
			wr_count <= 8'h00;
		end else if (ext_port_c_req) begin
			wr_count <= wr_count + 8'h01;
			wr_we    <= ext_port_c_we;
			wr_data  <= ext_port_c_wdata;
		end
	end
endmodule : pin_world

//--- dv/parallel_io_ports_bench.sv
// self-checking bench for the parallel i/o ports
`timescale 1ns/10ps
module parallel_io_ports_bench;
	import pio_pkg::*;
	localparam logic [7:0] EXT_RD = 8'hC3;
	logic clock, sys_rst, awvalid, wvalid, bready, arvalid, rready, strobe_a_input;
	logic awready, wready, bvalid, arready, rvalid, ext_port_c_req, ext_port_c_we;
	logic spi_master_select, mode_fault_disable, oc_pa3_ctrl, oc_pa3_val, wr_we;
	logic [1:0] mode_strap, bresp, rresp;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [2:0] timer_oc_en, timer_oc_val;
	logic [7:0] a_in, a_out, a_oe, b_out, addr_high, c_in, c_out, c_oe, ext_ad_out, ext_ad_oe;
	logic [7:0] ext_port_c_wdata, ext_port_c_rdata, ext_a, ext_c, wr_count, wr_data;
	logic [5:0] d_in, d_out, d_oe, alt_d_en, alt_d_out, alt_d_oe, ext_d;
	logic [31:0] rd_val;
	logic [1:0] rsp;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	pio_ports u_dut (.clock, .sys_rst, .mode_strap, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.a_in, .a_out, .a_oe, .timer_oc_en, .timer_oc_val, .oc_pa3_ctrl, .oc_pa3_val, .b_out, .addr_high,
		.c_in, .c_out, .c_oe, .strobe_a_input, .ext_ad_out, .ext_ad_oe, .ext_port_c_req, .ext_port_c_we,
		.ext_port_c_wdata, .ext_port_c_rdata, .d_in, .d_out, .d_oe, .alt_d_en, .alt_d_out, .alt_d_oe,
		.spi_master_select, .mode_fault_disable);

	pin_world #(.EXT_RD(EXT_RD)) u_world (.clock, .sys_rst, .a_out, .a_oe, .c_out, .c_oe, .d_out, .d_oe, .ext_a,
		.ext_c, .ext_d, .a_in, .c_in, .d_in, .ext_port_c_req, .ext_port_c_we, .ext_port_c_wdata,
		.ext_port_c_rdata, .wr_count, .wr_we, .wr_data);

	// =====================================================================
	// clock and hang guard
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// =====================================================================
	// comparison and verdict
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	// =====================================================================
	// axi4-lite master; the leading edge keeps ready drops and raises apart
	task automatic wr(input logic [13:0] idx, input logic [7:0] d, output logic [1:0] r);
		@(posedge clock);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic wchk(input logic [13:0] idx, input logic [7:0] d);
		logic [1:0] r;
		wr(idx, d, r);
		check("write resp", 32'(r), 32'(RESP_OKAY));
	endtask : wchk

	task automatic rchk(input string what, input logic [13:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		check(what, d, {24'h0, exp});
		check("read resp", 32'(r), 32'(RESP_OKAY));
	endtask : rchk

	task automatic do_reset(input logic [1:0] m);
		@(posedge clock);
		mode_strap <= m;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
	endtask : do_reset

	// =====================================================================
	// test sequence
	initial begin
		clock = 0; sys_rst = 1; mode_strap = 2'h1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF;
		awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; strobe_a_input = 0;
		timer_oc_en = 3'h5; timer_oc_val = 3'h4; oc_pa3_ctrl = 0; oc_pa3_val = 0; addr_high = 8'h9C;
		ext_ad_out = 8'h6B; ext_ad_oe = 8'hF0; ext_a = 8'h00; ext_c = 8'h5A; ext_d = 6'h00;
		alt_d_en = 0; alt_d_out = 0; alt_d_oe = 0; spi_master_select = 0;
		for (int m = 0; m < 4; m++) begin
			do_reset(m[1:0]);
			check("port b pins", 32'(b_out), (m < 2) ? 32'h0 : 32'(addr_high));
		end
		check("port c out", 32'(c_out), 32'(ext_ad_out));
		check("port c oe", 32'(c_oe), 32'(ext_ad_oe));
		wchk(IDX_PORT_C, 8'h44);
		// the far side logs the request on the edge that ends the write
		#1;
		check("ext write", {15'h0, wr_we, wr_count, wr_data}, 32'h10144);
		rchk("ext read", IDX_PORT_C, EXT_RD);
		do_reset(2'h1);
		check("port c out reset", 32'(c_out), 32'h0);
		check("port c oe reset", 32'(c_oe), 32'h0);
		check("port d oe reset", 32'(d_oe), 32'h0);
		check("port a oe reset", 32'(a_oe), 32'h70);
		rchk("port c dir", IDX_PORT_C_DIR, 8'h00);
		rchk("port d dir", IDX_PORT_D_DIR, 8'h00);
		rchk("control", IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR, 8'h00);
		rchk("strobe ctl", IDX_STROBE_CTL, 8'h02);
		wchk(IDX_PORT_B, 8'hA5);
		check("port b data", 32'(b_out), 32'hA5);
		wchk(IDX_PORT_C_DIR, 8'hF0);
		wchk(IDX_PORT_C, 8'h3C);
		check("port c oe", 32'(c_oe), 32'hF0);
		check("port c out", 32'(c_out), 32'h3C);
		repeat (4) @(posedge clock);
		rchk("port c mixed", IDX_PORT_C, 8'h3A);
		wchk(IDX_PORT_D_DIR, 8'hFF);
		rchk("port d dir", IDX_PORT_D_DIR, 8'h3F);
		check("port d oe", 32'(d_oe), 32'h3F);
		wchk(IDX_PORT_D, 8'hFF);
		repeat (4) @(posedge clock);
		rchk("port d data", IDX_PORT_D, 8'h3F);
		alt_d_en <= 6'h02;
		spi_master_select <= 1'b1;
		@(posedge clock);
		#1;
		check("port d alt oe", 32'(d_oe), 32'h3D);
		check("port d alt out", 32'(d_out), 32'h3D);
		check("fault off", 32'(mode_fault_disable), 32'h1);
		wchk(IDX_PORT_D_DIR, 8'h1F);
		check("fault on", 32'(mode_fault_disable), 32'h0);
		wchk(IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR, 8'h88);
		check("port a oe dirs", 32'(a_oe), 32'hF8);
		wchk(IDX_PULSE_ACCUM_CTRL_AND_PORT_A_DATA_DIR, 8'h00);
		oc_pa3_ctrl <= 1'b1;
		oc_pa3_val <= 1'b1;
		@(posedge clock);
		#1;
		check("pin a3 override", 32'({a_oe, a_out[3]}), 32'hF1);
		wchk(IDX_PORT_A, 8'hF0);
		check("port a out", 32'(a_out), 32'hE8);
		rchk("port a", IDX_PORT_A, 8'h78);
		wchk(IDX_PORT_C_DIR, 8'h00);
		strobe_a_input <= 1'b1;
		repeat (8) @(posedge clock);
		rchk("strobe flag set", IDX_STROBE_CTL, 8'h82);
		rchk("latch rising", IDX_PORT_C_LAT, 8'h5A);
		rchk("strobe flag clear", IDX_STROBE_CTL, 8'h02);
		// falling edge selected: the fall captures, the later rise must not
		wchk(IDX_STROBE_CTL, 8'h00);
		ext_c <= 8'h11;
		repeat (4) @(posedge clock);
		strobe_a_input <= 1'b0;
		repeat (8) @(posedge clock);
		ext_c <= 8'h22;
		repeat (4) @(posedge clock);
		strobe_a_input <= 1'b1;
		repeat (8) @(posedge clock);
		rchk("latch falling", IDX_PORT_C_LAT, 8'h11);
		wchk(IDX_PORT_C_LAT, 8'h77);
		check("latch write", 32'(c_out), 32'h77);
		wr(14'h0000, 8'h12, rsp);
		check("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
		rd(14'h0000, rd_val, rsp);
		check("unmapped read", {rd_val[29:0], rsp}, 32'(RESP_SLVERR));
		give_verdict();
	end
endmodule : parallel_io_ports_bench
